// ### bench/host_model.sv
`timescale 1ns/100ps
module host_model
    import drv_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Link pins
    output link_in_t link_in
);
    // ========
    // Controller
    initial link_in = LINK_IDLE;
    task automatic wait_c(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_c
    // Stale data inverted, so an early sample shows
    task automatic shift(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            link_in.sdata <= ~b[i];
            wait_c(2);
            link_in.sdata <= b[i];
            wait_c(2);
            link_in.sclk <= 1'b1;
            wait_c(4);
            link_in.sclk <= 1'b0;
        end
    endtask : shift
    task automatic load();
        wait_c(30);
        link_in.strobe <= 1'b1;
        wait_c(10);
        link_in.strobe <= 1'b0;
        wait_c(6);
    endtask : load
    // Latches left open, so blanking must cover the whole shift
    task automatic bypass(input logic [7:0] b);
        link_in.blank <= 1'b1;
        link_in.strobe <= 1'b1;
        wait_c(8);
        shift(b);
        wait_c(30);
        link_in.blank <= 1'b0;
        wait_c(8);
        link_in.strobe <= 1'b0;
        wait_c(6);
    endtask : bypass
    task automatic set_blank(input logic v);
        link_in.blank <= v;
        wait_c(8);
    endtask : set_blank
endmodule : host_model

// ### bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import drv_pkg::*;
    // ========
    // Bench
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    link_in_t link_in;
    logic [7:0] drive_out;
    logic cascade_out;
    logic [7:0] exp_q[$];
    logic [7:0] b;
    logic [7:0] prev;
    logic [7:0] note;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    initial forever #5 core_clk = ~core_clk;
    host_model u_host (.core_clk(core_clk), .link_in(link_in));
    latched_driver #(.N(8)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .link_in(link_in),
        .drive_out(drive_out), .cascade_out(cascade_out));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    // Off reads high, so all-high and a repeat would show no change
    function automatic logic [7:0] pick(input logic [7:0] avoid);
        logic [7:0] v;
        v = 8'($urandom);
        while (v == avoid || v == 8'hff) v = 8'($urandom);
        return v;
    endfunction : pick
    // Any unexpected change finds a wrong or empty note
    always @(drive_out) begin
        if (rst_n) begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            check("drive_out", drive_out, note);
        end
    end
    always @(posedge core_clk) if (++cyc == 20000) begin
        fails++;
        test_done();
    end
    initial begin
        void'($urandom(73));
        prev = 8'h00;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        exp_q.push_back(8'h00);
        u_host.set_blank(1'b0);
        for (int k = 0; k < 6; k++) begin
            b = pick(prev);
            u_host.shift(b);
            check("cascade", {7'h00, cascade_out}, {7'h00, b[7]});
            exp_q.push_back(b);
            u_host.load();
            exp_q.push_back(8'hff);
            u_host.set_blank(1'b1);
            exp_q.push_back(b);
            u_host.set_blank(1'b0);
            prev = b;
        end
        b = pick(prev);
        exp_q.push_back(8'hff);
        exp_q.push_back(b);
        u_host.bypass(b);
        check("cascade", {7'h00, cascade_out}, {7'h00, b[7]});
        check("pending", 8'(exp_q.size()), 8'h00);
        test_done();
    end
endmodule : tb_top

// ### verilog/drv_pkg.sv
// Contract
// - Rising link clock captures serial input
// - Later rising edges shift toward cascade output
// - Strobe high: latches follow shift stages
// - Strobe low: latches hold their value
// - Blank high: outputs off, storage unchanged
// - Blank low: outputs follow latches
package drv_pkg;
    localparam int STAGES = 8;
    localparam logic [7:0] STAGE_RST = 8'h00;
    localparam logic [7:0] OUT_OFF = 8'hff;

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic strobe;
        logic blank;
    } link_in_t;

    // Pins at rest: link clock low, outputs blanked
    localparam link_in_t LINK_IDLE = 4'h1;
endpackage : drv_pkg

// ### verilog/latched_driver.sv
`timescale 1ns/100ps
module latched_driver
    import drv_pkg::*;
#(
    parameter int N = STAGES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Link pins
    input wire link_in_t link_in,
    // Driver outputs and cascade
    output logic [N-1:0] drive_out,
    output logic cascade_out
);
    // ====================================================
    // Checks
    // A single stage has no lower slice to shift from
    if (N < 2 || N > 8) begin : g_bad_n
        $error("N must be 2..8");
    end

    // ====================================================
    // Helpers
    // One shift step: the new bit enters stage 0
    function automatic logic [N-1:0] shift_in(
        input logic [N-1:0] stages,
        input logic bit_in
    );
        return {stages[N-2:0], bit_in};
    endfunction : shift_in

    // Output level; an off output reads high
    function automatic logic [N-1:0] out_level(
        input logic blank_in,
        input logic [N-1:0] held
    );
        return blank_in ? OUT_OFF[N-1:0] : held;
    endfunction : out_level

    // ====================================================
    // Pin synchronisation
    link_in_t s;
    logic sclk_prev_q;
    logic rise;
    logic [N-1:0] shift_q;
    logic [N-1:0] latch_q;

    // Resets to idle pins; a zero blank would flash outputs on after reset
    sync2 #(.WIDTH(4), .RST_VAL(LINK_IDLE)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(link_in),
        .sync_out(s)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= s.sclk;
        end
    end

    assign rise = s.sclk && !sclk_prev_q;

    // ====================================================
    // Shift register
    // Data is sampled with the clock through matching synchronisers, so setup
    // ahead of the edge by the controller carries through.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= STAGE_RST[N-1:0];
        end else if (rise) begin
            shift_q <= shift_in(shift_q, s.sdata);
        end
    end

    assign cascade_out = shift_q[N-1];

    // ====================================================
    // Latches
    // Transparency is one core cycle late; fine against link timing.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= STAGE_RST[N-1:0];
        end else if (s.strobe) begin
            latch_q <= shift_q;
        end
    end

    // ====================================================
    // Output stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_out <= OUT_OFF[N-1:0];
        end else if (s.blank) begin
            drive_out <= OUT_OFF[N-1:0];
        end else begin
            drive_out <= latch_q;
        end
    end

    // ====================================================
    // Assertions, shift register
    // Strobe and blank must never stall shifting
    shift_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rise |=> shift_q == shift_in($past(shift_q), $past(s.sdata)))
        else $error("shift register did not capture");

    shift_enter_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rise |=> shift_q[0] == $past(s.sdata))
        else $error("first stage missed serial bit");

    shift_move_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rise |=> shift_q[N-1:1] == $past(shift_q[N-2:0]))
        else $error("stages did not move along");

    shift_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rise |=> $stable(shift_q))
        else $error("shift register moved without clock edge");

    shift_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $changed(shift_q) |-> $past(rise))
        else $error("shift register changed off an edge");

    edge_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rise |=> !rise)
        else $error("one link edge seen twice");

    blank_shift_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s.blank && rise |=> shift_q == shift_in($past(shift_q), $past(s.sdata)))
        else $error("blanking stalled shifting");

    strobe_shift_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s.strobe && rise |=> shift_q == shift_in($past(shift_q), $past(s.sdata)))
        else $error("open latches stalled shifting");

    // ====================================================
    // Assertions, latches
    // Sampled latch trails the register by one core cycle
    latch_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s.strobe |=> latch_q == $past(shift_q))
        else $error("latch not transparent");

    latch_open_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s.strobe && $past(s.strobe) && $stable(shift_q) |=> $stable(latch_q))
        else $error("open latch moved with steady register");

    latch_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !s.strobe |=> $stable(latch_q))
        else $error("latch changed while closed");

    latch_shift_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !s.strobe && rise |=> $stable(latch_q))
        else $error("closed latch followed shifting");

    latch_blank_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !s.strobe && s.blank |=> $stable(latch_q))
        else $error("closed latch moved while blanked");

    blank_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s.blank && s.strobe |=> latch_q == $past(shift_q))
        else $error("blanking stopped latch loading");

    // ====================================================
    // Assertions, outputs
    // Outputs lag the pins by three to five core cycles
    blank_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s.blank |=> drive_out == OUT_OFF[N-1:0])
        else $error("outputs not off while blanked");

    blank_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s.blank && !s.strobe && !rise) |=> $stable(latch_q) && $stable(shift_q))
        else $error("blanking disturbed storage");

    blank_still_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s.blank && $past(s.blank) |=> $stable(drive_out))
        else $error("blanked outputs moved");

    out_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !s.blank |=> drive_out == $past(latch_q))
        else $error("outputs not following latches");

    out_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> drive_out == out_level($past(s.blank), $past(latch_q)))
        else $error("output level wrong");

    out_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !s.blank && !$past(s.blank) && $stable(latch_q) |=> $stable(drive_out))
        else $error("outputs moved with steady latches");

    closed_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !s.strobe && !$past(s.strobe) && !s.blank && !$past(s.blank) |=> $stable(drive_out))
        else $error("outputs moved while latches closed");

    load_path_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s.strobe ##1 !s.blank |=> drive_out == $past(shift_q, 2))
        else $error("loaded stages did not reach outputs");

    bypass_path_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s.strobe && !s.blank ##1 s.strobe && !s.blank |=> drive_out == $past(shift_q, 2))
        else $error("bypassed latches did not reach outputs");

    // ====================================================
    // Assertions, cascade
    // The cascade is a plain flop, so a chained part sees clean edges
    cascade_now_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cascade_out == shift_q[N-1])
        else $error("cascade output not last stage");

    cascade_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rise |=> $stable(cascade_out))
        else $error("cascade output moved without clock edge");

    cascade_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $changed(cascade_out) |-> $past(rise))
        else $error("cascade output changed off an edge");

    cascade_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rise |=> cascade_out == $past(shift_q[N-2]))
        else $error("cascade output missed stage move");
endmodule : latched_driver

// ### verilog/sync2.sv
`timescale 1ns/100ps
module sync2 #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sync2
